// *** verilog/rmcg_pkg.sv ***
/*
  Package for the run-mode clock gating block: register map, field
  positions, reset values, bus types and sample-rate encodings.
  Assumes a 32-bit AXI4-Lite register bus and a single system clock.
*/
package rmcg_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] RMCG_OFF_RUN    = 12'h100;
  localparam logic [11:0] RMCG_OFF_SLEEP  = 12'h110;
  localparam logic [11:0] RMCG_OFF_DEEP   = 12'h120;
  localparam logic [11:0] RMCG_OFF_CONFIG = 12'h130;
  localparam logic [11:0] RMCG_OFF_STATUS = 12'h134;
  localparam logic [11:0] RMCG_OFF_MASK   = 12'h138;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          RMCG_BIT_ADC    = 16;
  localparam int          RMCG_BIT_SPD_HI = 9;
  localparam int          RMCG_BIT_SPD_LO = 8;
  localparam int          RMCG_BIT_HIB    = 6;
  localparam int          RMCG_BIT_WDT    = 3;
  localparam logic [31:0] RMCG_GATE_WMASK = 32'h0001_0348;
  localparam logic [31:0] RMCG_GATE_RESET = 32'h0000_0040;
  localparam int          RMCG_BIT_AUTO   = 0;
  localparam logic [31:0] RMCG_CFG_RESET  = 32'h0000_0000;
  localparam logic [31:0] RMCG_CFG_WMASK  = 32'h0000_0001;
  // status events: bit0 adc fault, bit1 watchdog fault
  localparam int          RMCG_EVT_ADC    = 0;
  localparam int          RMCG_EVT_WDT    = 1;
  localparam logic [31:0] RMCG_EVT_WMASK  = 32'h0000_0003;

  // ---------------------------------------------------------------
  // sample-rate encodings and bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RMCG_SPD_125K = 2'h0;
  localparam logic [1:0] RMCG_SPD_250K = 2'h1;
  localparam logic [1:0] RMCG_SPD_500K = 2'h2;
  localparam logic [1:0] RMCG_RESP_OK  = 2'h0;
  localparam logic [1:0] RMCG_RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    RMCG_MODE_RUN   = 2'h0,
    RMCG_MODE_SLEEP = 2'h1,
    RMCG_MODE_DEEP  = 2'h2
  } rmcg_mode_t;

  typedef struct packed {
    logic        adcEn;
    logic        hibEn;
    logic        wdtEn;
    logic [1:0]  sampleSpeed;
  } rmcg_enables_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic        err;
  } rmcg_periph_req_t;

endpackage

// *** verilog/rmcg_clock_gate.sv ***
/*
  Glitch-free clock gate: enable is latched while the clock is low.
  Assumes enable comes from flip-flops on the same clock.
*/
`timescale 1ns/1ns
module rmcg_clock_gate
  import rmcg_pkg::*;
(
  input  wire logic clk,
  input  wire logic enable,
  output logic      gatedClk
);

  logic latchEn;

  // transparent-low latch keeps the enable stable through the high phase
  always_latch begin
    if (!clk) begin
      latchEn = enable;
    end
  end

  assign gatedClk = clk & latchEn;

endmodule

// *** verilog/rmcg_run_mode_clock_gating.sv ***
/*
  Run-mode clock gating: run, sleep and deep-sleep gate registers,
  auto-gating select, peripheral access check with bus fault, event
  status with mask and interrupt, three glitch-free clock gates.
  Register words: run 0x100, sleep 0x110, deep sleep 0x120, config
  0x130 (bit 0 auto gating), status 0x134 (bit 0 converter fault,
  bit 1 watchdog fault, write one to clear), mask 0x138.
  Gate words share one layout: converter bit 16, sample speed 9:8,
  hibernation bit 6, watchdog bit 3; every other bit reads zero.
  A write lands one cycle after address and data are both held; the
  unit enables follow one cycle later and the gated clocks at the
  next low phase of clk.
  Assumes an AXI4-Lite master on clk and a power controller that
  reports the current operating mode; peripheral selects and the
  access strobe come from the bus decoder on the same clock.
*/
`timescale 1ns/1ns
module rmcg_run_mode_clock_gating
  import rmcg_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [11:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [11:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire rmcg_mode_t       powerMode,
  input  wire logic             adcSel,
  input  wire logic             wdtSel,
  input  wire logic             periphAccess,
  output logic                  accessFault,
  output logic                  adcClk,
  output logic                  hibClk,
  output logic                  wdtClk,
  output logic                  adcClkEn,
  output logic                  hibClkEn,
  output logic                  wdtClkEn,
  output logic [1:0]            converterSampleSpeed,
  output logic                  irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0]   runGate;
    logic [31:0]   sleepGate;
    logic [31:0]   deepGate;
    logic [31:0]   autoCfg;
    logic [31:0]   status;
    logic [31:0]   mask;
    logic          awHeld;
    logic [11:0]   awAddr;
    logic          wHeld;
    logic [31:0]   wData;
    logic [3:0]    wStrb;
    logic          bValid;
    logic [1:0]    bResp;
    logic          rValid;
    logic [31:0]   rData;
    logic [1:0]    rResp;
    rmcg_enables_t enables;
    logic          fault;
  } rmcg_state_t;

  localparam rmcg_state_t RMCG_STATE_RESET = '{
    runGate:   RMCG_GATE_RESET,
    sleepGate: RMCG_GATE_RESET,
    deepGate:  RMCG_GATE_RESET,
    autoCfg:   RMCG_CFG_RESET,
    enables:   '{adcEn: 1'b0, hibEn: 1'b1, wdtEn: 1'b0,
                 sampleSpeed: RMCG_SPD_125K},
    default:   '0
  };

  rmcg_state_t state_reg;
  rmcg_state_t state_next;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] strobeMerge(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0]  strb,
    input logic [31:0] wmask
  );
    logic [31:0] merged;
    merged = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merged[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return merged & wmask;
  endfunction

  function automatic logic isMapped(input logic [11:0] a);
    return a == RMCG_OFF_RUN || a == RMCG_OFF_SLEEP ||
           a == RMCG_OFF_DEEP || a == RMCG_OFF_CONFIG ||
           a == RMCG_OFF_STATUS || a == RMCG_OFF_MASK;
  endfunction

  // gate word to the per-unit enables and sample-rate field
  function automatic rmcg_enables_t gateDecode(input logic [31:0] g);
    rmcg_enables_t e;
    e.adcEn       = g[RMCG_BIT_ADC];
    e.hibEn       = g[RMCG_BIT_HIB];
    e.wdtEn       = g[RMCG_BIT_WDT];
    e.sampleSpeed = g[RMCG_BIT_SPD_HI:RMCG_BIT_SPD_LO];
    return e;
  endfunction

  // an access hits a gated unit when selected and not clocked
  function automatic logic faultHit(
    input logic acc,
    input logic sel,
    input logic clkOn
  );
    return acc && sel && !clkOn;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [31:0] activeGate;
  logic        adcFault;
  logic        wdtFault;
  logic        doWrite;
  logic [31:0] events;

  always_comb begin
    state_next = state_reg;
    activeGate = state_reg.runGate;
    events     = '0;

    // auto gating applies the sleep register in sleep mode and the deep-sleep register in deep sleep
    if (state_reg.autoCfg[RMCG_BIT_AUTO]) begin
      case (powerMode)
        RMCG_MODE_SLEEP: activeGate = state_reg.sleepGate;
        RMCG_MODE_DEEP:  activeGate = state_reg.deepGate;
        RMCG_MODE_RUN:   activeGate = state_reg.runGate;
        default:         activeGate = state_reg.runGate;
      endcase
    end

    // registered enables: a write shows one cycle after it lands
    state_next.enables = gateDecode(activeGate);

    // access to an unclocked peripheral faults
    adcFault = faultHit(periphAccess, adcSel, state_reg.enables.adcEn);
    wdtFault = faultHit(periphAccess, wdtSel, state_reg.enables.wdtEn);
    state_next.fault = adcFault || wdtFault;
    events[RMCG_EVT_ADC] = adcFault;
    events[RMCG_EVT_WDT] = wdtFault;

    // write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.awHeld = 1'b1;
      state_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.wHeld = 1'b1;
      state_next.wData = s_axi_wdata;
      state_next.wStrb = s_axi_wstrb;
    end
    if (state_reg.bValid && s_axi_bready) begin
      state_next.bValid = 1'b0;
    end

    doWrite = state_reg.awHeld && state_reg.wHeld && !state_reg.bValid;
    if (doWrite) begin
      state_next.awHeld = 1'b0;
      state_next.wHeld  = 1'b0;
      state_next.bValid = 1'b1;
      state_next.bResp  = isMapped(state_reg.awAddr) ?
                          RMCG_RESP_OK : RMCG_RESP_ERR;
      case (state_reg.awAddr)
        RMCG_OFF_RUN: state_next.runGate = strobeMerge(
          state_reg.runGate, state_reg.wData, state_reg.wStrb,
          RMCG_GATE_WMASK);
        RMCG_OFF_SLEEP: state_next.sleepGate = strobeMerge(
          state_reg.sleepGate, state_reg.wData, state_reg.wStrb,
          RMCG_GATE_WMASK);
        RMCG_OFF_DEEP: state_next.deepGate = strobeMerge(
          state_reg.deepGate, state_reg.wData, state_reg.wStrb,
          RMCG_GATE_WMASK);
        RMCG_OFF_CONFIG: state_next.autoCfg = strobeMerge(
          state_reg.autoCfg, state_reg.wData, state_reg.wStrb,
          RMCG_CFG_WMASK);
        RMCG_OFF_MASK: state_next.mask = strobeMerge(
          state_reg.mask, state_reg.wData, state_reg.wStrb,
          RMCG_EVT_WMASK);
        RMCG_OFF_STATUS: state_next.status = state_reg.status &
          ~strobeMerge('0, state_reg.wData, state_reg.wStrb,
                       RMCG_EVT_WMASK);
        default: ;
      endcase
    end
    // new events win over a clearing write in the same cycle
    state_next.status = state_next.status | events;

    // reads
    if (state_reg.rValid && s_axi_rready) begin
      state_next.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      state_next.rValid = 1'b1;
      state_next.rResp  = isMapped(s_axi_araddr) ?
                          RMCG_RESP_OK : RMCG_RESP_ERR;
      case (s_axi_araddr)
        RMCG_OFF_RUN:    state_next.rData = state_reg.runGate;
        RMCG_OFF_SLEEP:  state_next.rData = state_reg.sleepGate;
        RMCG_OFF_DEEP:   state_next.rData = state_reg.deepGate;
        RMCG_OFF_CONFIG: state_next.rData = state_reg.autoCfg;
        RMCG_OFF_STATUS: state_next.rData = state_reg.status;
        RMCG_OFF_MASK:   state_next.rData = state_reg.mask;
        default:         state_next.rData = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= RMCG_STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // bus handshakes and outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = !state_reg.awHeld;
  assign s_axi_wready  = !state_reg.wHeld;
  assign s_axi_bvalid  = state_reg.bValid;
  assign s_axi_bresp   = state_reg.bResp;
  // one read in flight; refuse a new address until data is taken
  assign s_axi_arready = !state_reg.rValid;
  assign s_axi_rvalid  = state_reg.rValid;
  assign s_axi_rdata   = state_reg.rData;
  assign s_axi_rresp   = state_reg.rResp;

  assign accessFault          = state_reg.fault;
  assign adcClkEn             = state_reg.enables.adcEn;
  assign hibClkEn             = state_reg.enables.hibEn;
  assign wdtClkEn             = state_reg.enables.wdtEn;
  // value 3 is kept as written; software keeps to the legal rates
  assign converterSampleSpeed = state_reg.enables.sampleSpeed;

  // ---------------------------------------------------------------
  // interrupt
  // ---------------------------------------------------------------
  assign irq = |(state_reg.status & state_reg.mask);

  // ---------------------------------------------------------------
  // gated clocks
  // ---------------------------------------------------------------
  rmcg_clock_gate adcGate (
    .clk      (clk),
    .enable   (state_reg.enables.adcEn),
    .gatedClk (adcClk)
  );

  rmcg_clock_gate hibGate (
    .clk      (clk),
    .enable   (state_reg.enables.hibEn),
    .gatedClk (hibClk)
  );

  rmcg_clock_gate wdtGate (
    .clk      (clk),
    .enable   (state_reg.enables.wdtEn),
    .gatedClk (wdtClk)
  );

endmodule

// *** bench/rmcg_properties.sv ***
/*
  Checker for the run-mode clock gating block, bound to its top.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ns
module rmcg_properties
  import rmcg_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire rmcg_mode_t powerMode,
  input wire logic       adcSel,
  input wire logic       wdtSel,
  input wire logic       periphAccess,
  input wire logic       accessFault,
  input wire logic       adcClkEn,
  input wire logic       hibClkEn,
  input wire logic       wdtClkEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // faults, enables and bus answers
  // ----------------------------------------
  // enables lag the register by a cycle, so skip just after a write
  adc_fault_a: assert property (
    periphAccess && adcSel && !adcClkEn && !$past(s_axi_bvalid)
    |=> accessFault) else $error("gated converter access not faulted");
  wdt_fault_a: assert property (
    periphAccess && wdtSel && !wdtClkEn && !$past(s_axi_bvalid)
    |=> accessFault) else $error("gated watchdog access not faulted");
  fault_cause_a: assert property (
    accessFault |-> $past(periphAccess))
    else $error("fault without an access");
  adc_open_a: assert property (
    periphAccess && adcSel && !wdtSel && adcClkEn && !$past(s_axi_bvalid)
    |=> !accessFault) else $error("clocked converter access faulted");
  reset_gates_a: assert property (
    $fell(rst) |-> hibClkEn && !adcClkEn && !wdtClkEn)
    else $error("wrong enables after reset");
  gate_change_a: assert property (
    ($changed(adcClkEn) || $changed(wdtClkEn) || $changed(hibClkEn))
    && powerMode == $past(powerMode) && powerMode == $past(powerMode, 2)
    |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("enable moved without a write");
  // both taken at one edge: held a cycle, written, then answered
  write_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write response late");
  read_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  cover property (accessFault);
  cover property ($rose(adcClkEn));
  cover property (wdtClkEn && powerMode == RMCG_MODE_SLEEP);
endmodule
bind rmcg_run_mode_clock_gating rmcg_properties i_rmcg_properties (.*);

// *** bench/tb_top.sv ***
/*
  Testbench for the run-mode clock gating block.
  Assumes the block answers AXI4-Lite requests on clk.
*/
`timescale 1ns/1ns
module tb_top
  import rmcg_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_rvalid;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, converterSampleSpeed, rs;
  rmcg_mode_t  powerMode = RMCG_MODE_RUN;
  logic        adcSel = 1'b0, wdtSel = 1'b0, periphAccess = 1'b0;
  logic        accessFault, irq;
  logic        adcClk, hibClk, wdtClk, adcClkEn, hibClkEn, wdtClkEn;
  int          failures = 0, compares = 0;
  always #50 clk = ~clk;
  rmcg_run_mode_clock_gating i_rmcg_run_mode_clock_gating (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .powerMode, .adcSel, .wdtSel,
    .periphAccess, .accessFault, .adcClk, .hibClk, .wdtClk, .adcClkEn,
    .hibClkEn, .wdtClkEn, .converterSampleSpeed, .irq);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic final_report();
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // a stuck handshake counts as a mismatch and ends the run
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 40) begin
      failures++;
      final_report();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    int n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk("rdata", rv, e);
  endtask
  task automatic en(input logic [2:0] e);
    repeat (3) @(posedge clk);
    chk("enables", 32'({adcClkEn, hibClkEn, wdtClkEn}), 32'(e));
  endtask
  // gated clocks follow clk while enabled and rest low in the low phase
  task automatic gclk(input logic [2:0] e);
    @(posedge clk);
    #10;
    chk("gclkHigh", 32'({adcClk, hibClk, wdtClk}), 32'(e));
    #50;
    chk("gclkLow", 32'({adcClk, hibClk, wdtClk}), 32'h0000_0000);
  endtask
  task automatic acc(input logic a, w, e);
    @(posedge clk);
    adcSel <= a;
    wdtSel <= w;
    periphAccess <= 1'b1;
    @(posedge clk);
    periphAccess <= 1'b0;
    @(posedge clk);
    chk("fault", 32'(accessFault), 32'(e));
  endtask
  task automatic irqIs(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", 32'(irq), 32'(e));
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rchk(RMCG_OFF_RUN, RMCG_GATE_RESET);
    en(3'b010);
    rchk(12'h0FC, 32'h0000_0000);
    chk("resp", 32'(rs), 32'(RMCG_RESP_ERR));
    wr(12'h0FC, 32'hFFFF_FFFF);
    chk("bresp", 32'(rs), 32'(RMCG_RESP_ERR));
    rchk(RMCG_OFF_RUN, RMCG_GATE_RESET);
  endtask
  task automatic t_speed();
    logic [31:0] w;
    // rates stay at or below the converter's fastest setting
    for (int s = 0; s < 3; s++) begin
      w = 32'h0001_0048 | (32'(s) << 8);
      wr(RMCG_OFF_RUN, w);
      chk("bresp", 32'(rs), 32'(RMCG_RESP_OK));
      rchk(RMCG_OFF_RUN, w);
      chk("speed", 32'(converterSampleSpeed), 32'(s));
    end
    en(3'b111);
    gclk(3'b111);
  endtask
  task automatic t_reserved();
    wr(RMCG_OFF_RUN, 32'hFFFF_FEFF);
    rchk(RMCG_OFF_RUN, 32'h0001_0248);
    s_axi_wstrb <= 4'h1;
    wr(RMCG_OFF_RUN, 32'h0000_0000);
    s_axi_wstrb <= 4'hF;
    rchk(RMCG_OFF_RUN, 32'h0001_0200);
    wr(RMCG_OFF_RUN, 32'hFFFE_FCB7);
    rchk(RMCG_OFF_RUN, 32'h0000_0000);
    en(3'b000);
    gclk(3'b000);
  endtask
  task automatic t_fault();
    acc(1'b1, 1'b0, 1'b1);
    rchk(RMCG_OFF_STATUS, 32'h0000_0001);
    irqIs(1'b0);
    wr(RMCG_OFF_MASK, 32'h0000_0001);
    irqIs(1'b1);
    wr(RMCG_OFF_STATUS, 32'h0000_0001);
    irqIs(1'b0);
    acc(1'b0, 1'b1, 1'b1);
    rchk(RMCG_OFF_STATUS, 32'h0000_0002);
    irqIs(1'b0);
    wr(RMCG_OFF_STATUS, 32'h0000_0002);
    wr(RMCG_OFF_RUN, 32'h0001_0008);
    acc(1'b1, 1'b0, 1'b0);
    acc(1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_sleep();
    wr(RMCG_OFF_SLEEP, 32'h0000_0040);
    powerMode <= RMCG_MODE_SLEEP;
    en(3'b101);
    wr(RMCG_OFF_CONFIG, 32'h0000_0001);
    en(3'b010);
    wr(RMCG_OFF_DEEP, 32'h0001_0000);
    powerMode <= RMCG_MODE_DEEP;
    en(3'b100);
    powerMode <= RMCG_MODE_RUN;
    en(3'b101);
    wr(RMCG_OFF_CONFIG, 32'h0000_0000);
  endtask
  // reset in mid-run brings the run, deep, config and mask words back to their reset values
  task automatic t_rerun();
    wr(RMCG_OFF_CONFIG, 32'h0000_0001);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(RMCG_OFF_RUN, RMCG_GATE_RESET);
    rchk(RMCG_OFF_DEEP, RMCG_GATE_RESET);
    rchk(RMCG_OFF_CONFIG, RMCG_CFG_RESET);
    rchk(RMCG_OFF_MASK, 32'h0000_0000);
    en(3'b010);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_speed();
    t_reserved();
    t_fault();
    t_sleep();
    t_rerun();
    final_report();
  end
endmodule
